// ==== bench/monitor_overflow_msi_status_tb_top.sv ====
// Self-checking bench for the overflow message and summary register bank
`timescale 1ns/10ps
module monitor_overflow_msi_status_tb_top;
    import mos_pkg::*;
    logic sys_clk = 1'b0, sys_rst = 1'b1, reg_req = 1'b0, reg_wr = 1'b0, reg_ack, msg_valid, msg_ready;
    logic c_rev = 1'b1, c_msg = 1'b1, c_sum = 1'b1, c_rme = 1'b1;
    logic [1:0] reg_space = 2'h0, msg_space;
    logic [AW-1:0] reg_addr = 12'h0;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, msg_data, lfsr = 32'ha1f8, pay [4], lab [4];
    logic [3:0] en = 4'h0, stall = 4'h0, wired;
    logic [15:0] csu = 16'h0, bw = 16'h0, bwl = 16'h0, msg_part;
    logic [63:0] csu_ris = 64'h0, bw_ris = 64'h0;
    logic [7:0] msg_pg;
    int err_total = 0, checked = 0;

    initial begin
        forever #5 sys_clk = ~sys_clk;
    end

    mos_regs mos_regs_inst (.sys_clk, .sys_rst, .cap_rev11(c_rev), .cap_msg_supported(c_msg),
        .cap_summary_supported(c_sum), .cap_realm_mgmt(c_rme), .reg_req, .reg_wr, .reg_space,
        .reg_addr, .reg_wdata, .reg_ack, .reg_rdata, .overflow_message_enable(en),
        .cache_usage_overflow_flag(csu), .cache_usage_instance(csu_ris), .bandwidth_overflow_flag(bw),
        .bandwidth_long_overflow_flag(bwl), .bandwidth_instance(bw_ris), .msg_valid, .msg_ready,
        .msg_space, .msg_data, .msg_partition_label(msg_part), .msg_perf_group_label(msg_pg),
        .wired_overflow_irq(wired));
    mos_msg_sink mos_msg_sink_inst (.sys_clk, .sys_rst, .msg_valid, .stall, .msg_ready);

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        lfsr = {lfsr[30:0], 1'b0} ^ (lfsr[31] ? 32'h0040_0007 : 32'h0);
        return lfsr;
    endfunction

    // Summary a state should show, built from the flags the bench drives
    function automatic logic [31:0] sum_exp(input int s);
        logic [31:0] v;
        v = 32'h0;
        for (int m = s * 4; m < s * 4 + 4; m++) begin
            if (csu[m]) begin
                v[31] = 1'b1;
                v[csu_ris[m*4+:4]] = 1'b1;
            end
            if (bw[m] || bwl[m]) begin
                v[30] = 1'b1;
                v[bw_ris[m*4+:4]] = 1'b1;
            end
        end
        return v;
    endfunction

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic acc(input logic wr, input int s, input logic [AW-1:0] ad, input logic [31:0] wd,
                       output logic [31:0] rd);
        int n;
        @(posedge sys_clk);
        reg_req <= 1'b1;
        reg_wr <= wr;
        reg_space <= 2'(s);
        reg_addr <= ad;
        reg_wdata <= wd;
        @(posedge sys_clk);
        reg_req <= 1'b0;
        for (n = 0; n < 4; n++) begin
            #1;
            if (reg_ack === 1'b1) break;
            @(posedge sys_clk);
        end
        rd = reg_rdata;
        if (n == 4) begin
            err_total++;
            $display("mismatch at %0t: no register answer", $time);
            tally_and_finish();
        end
    endtask

    task automatic caps(input logic [3:0] c);
        @(posedge sys_clk);
        {c_rev, c_msg, c_sum, c_rme} <= c;
        repeat (3) @(posedge sys_clk);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [31:0] rd;
        logic [31:0] ex;
        int k;
        repeat (16) @(posedge sys_clk);
        sys_rst <= 1'b0;
        for (int s = 0; s < NSP; s++) begin
            pay[s] = rnd();
            lab[s] = rnd();
            acc(1'b1, s, OFS_PAYLOAD, pay[s], rd);
            acc(1'b1, s, OFS_LABEL, lab[s], rd);
        end
        // Read back only after all four pages were written, so copies cannot alias
        for (int s = 0; s < NSP; s++) begin
            acc(1'b0, s, OFS_PAYLOAD, 32'h0, rd);
            chk(rd, pay[s], "payload");
            acc(1'b0, s, OFS_LABEL, 32'h0, rd);
            chk(rd, lab[s] & 32'h00ff_ffff, "label");
            acc(1'b0, s, 12'h8e4, 32'h0, rd);
            chk(rd, 32'h0, "unmapped");
        end
        for (int i = 0; i < 6; i++) begin
            @(posedge sys_clk);
            csu <= rnd() & rnd();
            bw <= rnd() & rnd();
            bwl <= (i == 0) ? 16'h0 : rnd() & rnd();
            csu_ris <= {rnd(), rnd()};
            bw_ris <= {rnd(), rnd()};
            repeat (3) @(posedge sys_clk);
            for (int s = 0; s < NSP; s++) begin
                acc(1'b1, s, OFS_SUMMARY, 32'hffff_ffff, rd);
                acc(1'b0, s, OFS_SUMMARY, 32'h0, rd);
                ex = sum_exp(s);
                chk(rd, ex, "summary");
                chk(32'(wired[s]), 32'(|ex[31:30]), "wired irq");
            end
        end
        caps(4'he);
        acc(1'b0, SP_ROOT, OFS_PAYLOAD, 32'h0, rd);
        chk(rd, 32'h0, "root page refused");
        acc(1'b1, SP_REALM, OFS_PAYLOAD, ~pay[3], rd);
        caps(4'h5);
        acc(1'b0, SP_NONSEC, OFS_LABEL, 32'h0, rd);
        chk(rd, 32'h0, "label absent");
        acc(1'b0, SP_SECURE, OFS_SUMMARY, 32'h0, rd);
        chk(rd, 32'h0, "summary absent");
        caps(4'hf);
        acc(1'b0, SP_REALM, OFS_PAYLOAD, 32'h0, rd);
        chk(rd, pay[3], "refused write kept out");
        @(posedge sys_clk);
        {csu, bw, bwl} <= 48'h0;
        for (int s = 0; s < NSP; s++) begin
            @(posedge sys_clk);
            en <= 4'h1 << s;
            stall <= 4'(rnd());
            @(posedge sys_clk);
            if (s[0]) bwl <= 16'h1 << (s * 4 + 3);
            else csu <= 16'h1 << (s * 4 + 1);
            for (k = 0; k < 40; k++) begin
                @(negedge sys_clk);
                if (msg_valid === 1'b1 && msg_ready === 1'b1) break;
            end
            chk(32'(k < 40), 32'h1, "message issued");
            if (k == 40) tally_and_finish();
            chk(32'(msg_space), 32'(s), "message state");
            chk(msg_data, pay[s], "message data");
            chk({8'h0, msg_pg, msg_part}, lab[s] & 32'h00ff_ffff, "message label");
            chk(32'(wired[s]), 32'h0, "wired irq held off");
            @(posedge sys_clk);
            {csu, bw, bwl} <= 48'h0;
            repeat (4) @(posedge sys_clk);
        end
        tally_and_finish();
    end
endmodule // monitor_overflow_msi_status_tb_top

// ==== bench/mos_msg_sink.sv ====
// Model of the bus side that accepts overflow message writes, prompt or slow
`timescale 1ns/10ps
module mos_msg_sink (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic msg_valid,
    input wire logic [3:0] stall,
    output logic msg_ready
);
    logic [3:0] wait_r;
    logic [3:0] wait_nxt;
    // Accept only after the commanded stall, so held fields are seen across waits
    assign msg_ready = msg_valid && (wait_r == stall);
    always_comb begin
        wait_nxt = wait_r + 4'h1;
        if (msg_ready || !msg_valid) begin
            wait_nxt = 4'h0;
        end
    end
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            wait_r <= 4'h0;
        end else begin
            wait_r <= wait_nxt;
        end
    end
endmodule // mos_msg_sink

// ==== verilog/mos_pkg.sv ====
// Constants and types for the monitor overflow message and summary register bank
package mos_pkg;
    localparam int NSP = 4;
    localparam int NCSU = 4;
    localparam int NMBWU = 4;
    localparam int NRIS = 16;
    localparam int RIS_W = 4;
    localparam int AW = 12;
    localparam logic [1:0] SP_SECURE = 2'h0;
    localparam logic [1:0] SP_NONSEC = 2'h1;
    localparam logic [1:0] SP_ROOT = 2'h2;
    localparam logic [1:0] SP_REALM = 2'h3;
    localparam logic [AW-1:0] OFS_LABEL = 12'h8dc;
    localparam logic [AW-1:0] OFS_PAYLOAD = 12'h8e8;
    localparam logic [AW-1:0] OFS_SUMMARY = 12'h8f0;
    localparam int LBL_PMG_LSB = 16;
    localparam int LBL_PMG_MSB = 23;
    localparam int LBL_PART_MSB = 15;
    localparam int SUM_CSU_BIT = 31;
    localparam int SUM_MBWU_BIT = 30;
    localparam logic [31:0] LABEL_MASK = 32'h00ff_ffff;
    localparam logic [31:0] LABEL_RST = 32'h0000_0000;
    localparam logic [31:0] PAYLOAD_RST = 32'h0000_0000;
    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
    typedef enum logic [0:0] {MOS_IDLE, MOS_SEND} mos_state_t;
endpackage

// ==== verilog/mos_regs.sv ====
// Monitor overflow message payload, label and summary registers, four security copies
//
// Overview of operation
// - Each state holds a full 32-bit payload word used as message data.
// - Four separate copies, one per security state, reached only via own page.
// - Payload decoded at 0x8e8, read-write in Secure and Non-secure pages.
// - Root and Realm copies are read-write only with realm management present.
// - Label register exists only with revision 1.1 and message support; else RAZ/WI.
// - Payload and label are implemented together whenever revision 1.1 and messages are supported.
// - Label register per state at 0x8dc, 32 bits, read-write.
// - Performance group in bits 23:16; bits 31:24 read zero; reset value undefined (reset here loads zero).
// - Partition label in bits 15:0; reset value undefined until written (reset here loads zero).
// - Secure copy labels Secure partitions, Non-secure copy Non-secure ones.
// - Read-only summary exists only with summary support; else reads zero.
// - Each state's summary covers only its own monitors.
// - Bit 31 set while any cache usage monitor has overflow set.
// - Bit 30 set while any bandwidth monitor has overflow or long overflow.
// - Bit r set when any monitor in instance r has an overflow flag.
// - Bit r is zero when instance r has no overflow flagged.
// - Message enable sends messages and suppresses wired interrupt; clear sends none.
// - Summary decoded at 0x8f0, read-only; in Root and Realm pages only with realm management.
`timescale 1ns/10ps
module mos_regs
    import mos_pkg::*;
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic cap_rev11,
    input wire logic cap_msg_supported,
    input wire logic cap_summary_supported,
    input wire logic cap_realm_mgmt,
    input wire logic reg_req,
    input wire logic reg_wr,
    input wire logic [1:0] reg_space,
    input wire logic [AW-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    output logic reg_ack,
    output logic [31:0] reg_rdata,
    input wire logic [NSP-1:0] overflow_message_enable,
    input wire logic [NSP*NCSU-1:0] cache_usage_overflow_flag,
    input wire logic [NSP*NCSU*RIS_W-1:0] cache_usage_instance,
    input wire logic [NSP*NMBWU-1:0] bandwidth_overflow_flag,
    input wire logic [NSP*NMBWU-1:0] bandwidth_long_overflow_flag,
    input wire logic [NSP*NMBWU*RIS_W-1:0] bandwidth_instance,
    output logic msg_valid,
    input wire logic msg_ready,
    output logic [1:0] msg_space,
    output logic [31:0] msg_data,
    output logic [LBL_PART_MSB:0] msg_partition_label,
    output logic [LBL_PMG_MSB-LBL_PMG_LSB:0] msg_perf_group_label,
    output logic [NSP-1:0] wired_overflow_irq
);

    ////////////////////////////////////////////////////////////////////////////
    // One-hot decode of a resource instance number, gated by its flag
    function automatic logic [NRIS-1:0] ris_hot(input logic [RIS_W-1:0] resource_instance_select, input logic flag);
        logic [NRIS-1:0] v;
        v = '0;
        v[resource_instance_select] = flag;
        return v;
    endfunction

    // Straps are pins: two flops before use, never loaded by the asynchronous reset
    logic rev11_m, msg_sup_m, sum_sup_m, realm_m;
    logic rev11_r, msg_sup_r, sum_sup_r, realm_r;
    always_ff @(posedge sys_clk) begin
        rev11_m <= cap_rev11;
        msg_sup_m <= cap_msg_supported;
        sum_sup_m <= cap_summary_supported;
        realm_m <= cap_realm_mgmt;
        rev11_r <= rev11_m;
        msg_sup_r <= msg_sup_m;
        sum_sup_r <= sum_sup_m;
        realm_r <= realm_m;
    end

    logic msg_regs_present;
    assign msg_regs_present = rev11_r & msg_sup_r;

    ////////////////////////////////////////////////////////////////////////////
    // Summary and new-overflow detection per security state
    logic [31:0] summary_nxt [NSP];
    logic [NSP-1:0] any_flag;
    genvar gs, gm;
    generate
        for (gs = 0; gs < NSP; gs++) begin : g_sp
            logic [NRIS-1:0] csu_ris [NCSU+1];
            logic [NRIS-1:0] bw_ris [NMBWU+1];
            logic csu_any, bw_any;
            assign csu_ris[0] = '0;
            assign bw_ris[0] = '0;
            for (gm = 0; gm < NCSU; gm++) begin : g_csu
                assign csu_ris[gm+1] = csu_ris[gm] | ris_hot(
                    cache_usage_instance[(gs*NCSU+gm)*RIS_W +: RIS_W],
                    cache_usage_overflow_flag[gs*NCSU+gm]);
            end
            for (gm = 0; gm < NMBWU; gm++) begin : g_bw
                assign bw_ris[gm+1] = bw_ris[gm] | ris_hot(
                    bandwidth_instance[(gs*NMBWU+gm)*RIS_W +: RIS_W],
                    bandwidth_overflow_flag[gs*NMBWU+gm] | bandwidth_long_overflow_flag[gs*NMBWU+gm]);
            end
            assign csu_any = |cache_usage_overflow_flag[gs*NCSU +: NCSU];
            assign bw_any = |(bandwidth_overflow_flag[gs*NMBWU +: NMBWU]
                | bandwidth_long_overflow_flag[gs*NMBWU +: NMBWU]);
            always_comb begin
                summary_nxt[gs] = ZERO_WORD;
                summary_nxt[gs][SUM_CSU_BIT] = csu_any;
                summary_nxt[gs][SUM_MBWU_BIT] = bw_any;
                summary_nxt[gs][NRIS-1:0] = csu_ris[NCSU] | bw_ris[NMBWU];
            end
            assign any_flag[gs] = csu_any | bw_any;
        end
    endgenerate

    logic [31:0] summary_r [NSP];
    logic [NSP-1:0] flag_prev_r;
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < NSP; i++) begin
                summary_r[i] <= ZERO_WORD;
            end
            flag_prev_r <= '0;
        end else begin
            for (int i = 0; i < NSP; i++) begin
                summary_r[i] <= summary_nxt[i];
            end
            flag_prev_r <= any_flag;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register access; each page reaches only its own copy
    logic [31:0] label_r [NSP];
    logic [31:0] payload_r [NSP];
    logic [31:0] label_nxt [NSP];
    logic [31:0] payload_nxt [NSP];
    logic ack_nxt;
    logic [31:0] rdata_nxt;
    logic page_ok;

    always_comb begin
        page_ok = (reg_space == SP_SECURE) || (reg_space == SP_NONSEC) || realm_r;
        for (int i = 0; i < NSP; i++) begin
            label_nxt[i] = label_r[i];
            payload_nxt[i] = payload_r[i];
        end
        ack_nxt = reg_req;
        rdata_nxt = ZERO_WORD;
        if (reg_req && page_ok) begin
            if (reg_addr == OFS_LABEL && msg_regs_present) begin
                if (reg_wr) begin
                    label_nxt[reg_space] = reg_wdata & LABEL_MASK;
                end else begin
                    rdata_nxt = label_r[reg_space];
                end
            end else if (reg_addr == OFS_PAYLOAD && msg_regs_present) begin
                if (reg_wr) begin
                    payload_nxt[reg_space] = reg_wdata;
                end else begin
                    rdata_nxt = payload_r[reg_space];
                end
            end else if (reg_addr == OFS_SUMMARY && sum_sup_r) begin
                if (!reg_wr) begin
                    rdata_nxt = summary_r[reg_space];
                end
            end
        end
    end

    // Label fields come up undefined by definition; a zero reset keeps simulation clean
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < NSP; i++) begin
                label_r[i] <= LABEL_RST;
                payload_r[i] <= PAYLOAD_RST;
            end
            reg_ack <= 1'b0;
            reg_rdata <= ZERO_WORD;
        end else begin
            for (int i = 0; i < NSP; i++) begin
                label_r[i] <= label_nxt[i];
                payload_r[i] <= payload_nxt[i];
            end
            reg_ack <= ack_nxt;
            reg_rdata <= rdata_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Message writes: a new overflow in an enabled state raises a request
    logic [NSP-1:0] pend_r, pend_nxt, new_ovf;
    mos_state_t state_r, state_nxt;
    logic [1:0] sel;
    logic msg_valid_nxt;
    logic [1:0] msg_space_nxt;
    logic [31:0] msg_data_nxt;
    logic [LBL_PART_MSB:0] msg_part_nxt;
    logic [LBL_PMG_MSB-LBL_PMG_LSB:0] msg_pmg_nxt;
    logic [NSP-1:0] irq_nxt;

    assign new_ovf = any_flag & ~flag_prev_r & overflow_message_enable & {NSP{msg_regs_present}};

    always_comb begin
        sel = SP_SECURE;
        for (int i = NSP - 1; i >= 0; i--) begin
            if (pend_r[i]) begin
                sel = 2'(i);
            end
        end
        state_nxt = state_r;
        pend_nxt = pend_r;
        msg_valid_nxt = msg_valid;
        msg_space_nxt = msg_space;
        msg_data_nxt = msg_data;
        msg_part_nxt = msg_partition_label;
        msg_pmg_nxt = msg_perf_group_label;
        case (state_r)
            MOS_IDLE: begin
                if (|pend_r) begin
                    state_nxt = MOS_SEND;
                    pend_nxt[sel] = 1'b0;
                    msg_valid_nxt = 1'b1;
                    msg_space_nxt = sel;
                    msg_data_nxt = payload_r[sel];
                    msg_part_nxt = label_r[sel][LBL_PART_MSB:0];
                    msg_pmg_nxt = label_r[sel][LBL_PMG_MSB:LBL_PMG_LSB];
                end
            end
            MOS_SEND: begin
                if (msg_ready) begin
                    state_nxt = MOS_IDLE;
                    msg_valid_nxt = 1'b0;
                end
            end
            default: state_nxt = MOS_IDLE;
        endcase
        // A fresh overflow wins over the clear of its own request
        pend_nxt = pend_nxt | new_ovf;
        irq_nxt = any_flag & ~overflow_message_enable;
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_r <= MOS_IDLE;
            pend_r <= '0;
            msg_valid <= 1'b0;
            msg_space <= SP_SECURE;
            msg_data <= ZERO_WORD;
            msg_partition_label <= '0;
            msg_perf_group_label <= '0;
            wired_overflow_irq <= '0;
        end else begin
            state_r <= state_nxt;
            pend_r <= pend_nxt;
            msg_valid <= msg_valid_nxt;
            msg_space <= msg_space_nxt;
            msg_data <= msg_data_nxt;
            msg_partition_label <= msg_part_nxt;
            msg_perf_group_label <= msg_pmg_nxt;
            wired_overflow_irq <= irq_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    a_csu_summary_bit: assert property (summary_r[0][SUM_CSU_BIT] == $past(|cache_usage_overflow_flag[NCSU-1:0]))
        else $error("cache usage summary bit wrong");
    a_bw_summary_bit: assert property (
        $fell(|(bandwidth_overflow_flag[NSP*NMBWU-1 -: NMBWU] | bandwidth_long_overflow_flag[NSP*NMBWU-1 -: NMBWU]))
        |=> !summary_r[NSP-1][SUM_MBWU_BIT])
        else $error("bandwidth summary bit not cleared");
    a_reserved_zero: assert property (summary_r[1][29:16] == 14'h0)
        else $error("reserved summary bits set");
    a_ris_empty_zero: assert property (!$past(any_flag[2]) |-> summary_r[2][NRIS-1:0] == 16'h0)
        else $error("instance bit set without overflow");
    a_summary_absent: assert property (reg_req && !reg_wr && reg_addr == OFS_SUMMARY && !sum_sup_r
        |=> reg_ack && reg_rdata == 32'h0)
        else $error("absent summary did not read zero");
    a_label_top_zero: assert property (reg_ack |-> !(reg_rdata[31:24] != 8'h0 && $past(reg_addr) == OFS_LABEL))
        else $error("label upper byte not zero");
    a_root_blocked: assert property (reg_req && reg_wr && reg_space == SP_ROOT && !realm_r
        |=> payload_r[SP_ROOT] == $past(payload_r[SP_ROOT]))
        else $error("root copy written without realm management");
    a_payload_write: assert property (reg_req && reg_wr && reg_addr == OFS_PAYLOAD && msg_regs_present && page_ok
        |=> payload_r[$past(reg_space)] == $past(reg_wdata))
        else $error("payload write lost");
    a_label_write: assert property (reg_req && reg_wr && reg_addr == OFS_LABEL && msg_regs_present && page_ok
        |=> label_r[$past(reg_space)] == ($past(reg_wdata) & LABEL_MASK))
        else $error("label write lost or upper byte kept");
    a_msg_payload: assert property ($rose(msg_valid) && !$past(reg_req && reg_wr)
        |-> msg_data == payload_r[msg_space])
        else $error("message carries wrong payload");
    a_msg_release: assert property (msg_valid && msg_ready |=> !msg_valid)
        else $error("message not released after accept");
    a_msg_hold: assert property (msg_valid && !msg_ready |=> msg_valid && $stable(msg_data))
        else $error("message dropped before accept");
    a_wired_suppress: assert property (overflow_message_enable[0] |=> !wired_overflow_irq[0])
        else $error("wired interrupt while messages enabled");

endmodule // mos_regs
